// >>> rtl/dci_ctrl.sv
// Controller-side driver of the control inputs
`timescale 1ns/1ps
`default_nettype none
module dci_ctrl #(
	parameter int DIV = 4
) (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	// Request
	input  wire logic                        req_valid,
	input  wire dci_pkg::dci_op_t            req_op,
	input  wire logic [dci_pkg::BANK_W-1:0]  req_bank,
	input  wire logic [dci_pkg::ROW_W-1:0]   req_addr,
	input  wire logic                        req_cke,
	input  wire logic                        req_odt,
	output logic                             req_ready,
	// Link
	dci_if.ctrl                              link
);
	logic [7:0] div_cnt;
	logic [2:0] burst_cnt;
	logic       ck;
	logic       issue;
	logic       rw_op;
	logic       cke_hold;

	// The divider needs an even ratio of at least four
	if (DIV < 4 || DIV > 255 || DIV % 2 != 0) begin : g_bad_div
		$error("link clock ratio must be even and between 4 and 255");
	end

	assign issue = req_valid && req_ready;
	assign rw_op = (req_op == dci_pkg::DCI_OP_READ) || (req_op == dci_pkg::DCI_OP_WRITE);

	// Clock divider drives the differential pair
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 8'h00;
			ck <= 1'b0;
		end else if (div_cnt == 8'(DIV / 2 - 1)) begin
			div_cnt <= 8'h00;
			ck <= ~ck;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// Commands launched just before the rising crossing
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			link.ck_t <= 1'b0;
			link.ck_c <= 1'b1;
			link.cs_n <= 1'b1;
			link.act_n <= 1'b1;
			link.cmd <= dci_pkg::CMD_NOP;
			link.addr <= 14'h0000;
			link.bank <= '0;
			link.odt <= 1'b0;
			link.cke <= 1'b0;
			req_ready <= 1'b0;
			burst_cnt <= 3'h0;
			cke_hold <= 1'b0;
		end else begin
			link.ck_t <= ck;
			link.ck_c <= ~ck;
			req_ready <= 1'b0;
			// Ready the cycle before the launch edge, so cs_n leads the rise by one cycle
			if (div_cnt == 8'(DIV / 2 - 2) && !ck) begin
				req_ready <= 1'b1;
			end
			// Launch edge: deselect unless a new request overrides
			if (div_cnt == 8'(DIV / 2 - 1) && !ck) begin
				link.cs_n <= 1'b1; // RULE_15
				link.act_n <= 1'b1;
				link.cmd <= dci_pkg::CMD_NOP;
				link.cke <= cke_hold || (burst_cnt != 3'h0); // RULE_05
				if (burst_cnt != 3'h0)
					burst_cnt <= burst_cnt - 3'h1;
			end
			if (issue) begin // RULE_01
				cke_hold <= req_cke;
				link.odt <= req_odt;
				link.cke <= req_cke || rw_op || (burst_cnt != 3'h0); // RULE_05
				link.bank <= req_bank;
				link.addr <= req_addr[13:0];
				if (req_op != dci_pkg::DCI_OP_NONE) begin
					link.cs_n <= 1'b0; // RULE_08
					link.act_n <= (req_op != dci_pkg::DCI_OP_ACT); // RULE_12
					unique case (req_op)
						dci_pkg::DCI_OP_ACT:
							link.cmd <= ~req_addr[dci_pkg::ROW_W-2:dci_pkg::ROWHI_POS]; // RULE_13
						dci_pkg::DCI_OP_READ:  link.cmd <= dci_pkg::CMD_READ;
						dci_pkg::DCI_OP_WRITE: link.cmd <= dci_pkg::CMD_WRITE;
						dci_pkg::DCI_OP_PRE:   link.cmd <= dci_pkg::CMD_PRE;
						dci_pkg::DCI_OP_REF:   link.cmd <= dci_pkg::CMD_REF;
						default:               link.cmd <= dci_pkg::CMD_NOP;
					endcase
					if (req_op == dci_pkg::DCI_OP_READ || req_op == dci_pkg::DCI_OP_WRITE)
						burst_cnt <= 3'(dci_pkg::BURST_CYCLES);
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dci_if.sv
// Interface carrying the control inputs between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface dci_if;
	logic       ck_t;
	logic       ck_c;
	logic       cke;
	logic       cs_n;
	logic       act_n;
	logic [2:0] cmd;
	logic [13:0] addr;
	logic [dci_pkg::BANK_W-1:0] bank;
	logic       odt;
	modport ctrl (output ck_t, output ck_c, output cke, output cs_n, output act_n,
		output cmd, output addr, output bank, output odt);
	modport mem (input ck_t, input ck_c, input cke, input cs_n, input act_n,
		input cmd, input addr, input bank, input odt);
endinterface
`default_nettype wire

// >>> rtl/dci_mem.sv
// Memory-side control-input front end
// How it works
// [RULE_01] Capture inputs on true-clock rise crossing
// [RULE_02] Clock enable high runs clocks and buffers
// [RULE_03] Low enable: idle powerdown/selfrefresh, else active powerdown
// [RULE_04] Self-refresh exit on asynchronous enable rise
// [RULE_05] Controller holds enable high during bursts
// [RULE_06] Power states gate all but allowed buffers
// [RULE_07] Commands ignored while chip select high
// [RULE_08] Chip select is part of command code
// [RULE_09] Registered termination control enables termination
// [RULE_10] Termination only on data, strobe, mask lines
// [RULE_11] Termination control ignored when nominal disabled
// [RULE_12] Activation input with select marks ACTIVATE
// [RULE_13] Activation low: command lines are row bits
// [RULE_14] Select, enable, termination excluded from parity
// [RULE_15] Controller deselects when issuing no command
`timescale 1ns/1ps
`default_nettype none
module dci_mem (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	// Link from controller
	dci_if.mem                               link,
	// Configuration
	input  wire logic                        rtt_nom_en,
	// Decoded command out
	output logic                             op_valid,
	output dci_pkg::dci_op_t                 op,
	output logic [dci_pkg::BANK_W-1:0]       op_bank,
	output logic [dci_pkg::ROW_W-1:0]        op_row,
	output logic [13:0]                      op_col,
	output logic                             cmd_parity,
	// Status
	output dci_pkg::dci_pstate_t             pstate,
	output logic                             clocks_run,
	output logic                             buf_ca_en,
	output logic                             buf_ck_odt_en,
	output logic                             term_dq_en,
	output logic                             term_ca_en
);
	logic                          ck_s1, ck_s2, ck_s3;
	logic                          cke_s1, cke_s2;
	logic                          cs_s1, cs_s2, act_s1, act_s2, odt_s1, odt_s2;
	logic [2:0]                    cmd_s1, cmd_s2;
	logic [13:0]                   addr_s1, addr_s2;
	logic [dci_pkg::BANK_W-1:0]    bank_s1, bank_s2;
	logic [dci_pkg::BANKS-1:0]     open_rows;
	logic                          edge_ck;
	logic                          cmd_take;
	logic                          pd_state;

	// Bank count must match the bank address width
	if (dci_pkg::BANKS != (1 << dci_pkg::BANK_W)) begin : g_bad_banks
		$error("bank count does not match bank address width");
	end

	// Two-stage sampling of the link clock and clock enable
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_s3 <= 1'b0;
			cke_s1 <= 1'b0;
			cke_s2 <= 1'b0;
		end else begin
			ck_s1 <= link.ck_t & ~link.ck_c;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			cke_s1 <= link.cke;
			cke_s2 <= cke_s1;
		end
	end

	// Two-stage sampling of the command and termination lines
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			act_s1 <= 1'b1;
			act_s2 <= 1'b1;
			odt_s1 <= 1'b0;
			odt_s2 <= 1'b0;
			cmd_s1 <= dci_pkg::CMD_NOP;
			cmd_s2 <= dci_pkg::CMD_NOP;
			addr_s1 <= 14'h0000;
			addr_s2 <= 14'h0000;
			bank_s1 <= '0;
			bank_s2 <= '0;
		end else begin
			cs_s1 <= link.cs_n;
			cs_s2 <= cs_s1;
			act_s1 <= link.act_n;
			act_s2 <= act_s1;
			odt_s1 <= link.odt;
			odt_s2 <= odt_s1;
			cmd_s1 <= link.cmd;
			cmd_s2 <= cmd_s1;
			addr_s1 <= link.addr;
			addr_s2 <= addr_s1;
			bank_s1 <= link.bank;
			bank_s2 <= bank_s1;
		end
	end

	assign edge_ck = ck_s2 & ~ck_s3; // RULE_01
	assign pd_state = (pstate == dci_pkg::DCI_PD_PRE) || (pstate == dci_pkg::DCI_PD_ACT)
		|| (pstate == dci_pkg::DCI_SELF_REF);
	assign cmd_take = edge_ck && clocks_run && !cs_s2; // RULE_07 RULE_08

	// Power state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pstate <= dci_pkg::DCI_IDLE;
		end else begin
			unique case (pstate)
				dci_pkg::DCI_IDLE, dci_pkg::DCI_ACTIVE: begin
					if (edge_ck && !cke_s2) begin
						if (|open_rows)
							pstate <= dci_pkg::DCI_PD_ACT; // RULE_03
						else if (!cs_s2 && act_s2 && cmd_s2 == dci_pkg::CMD_REF)
							pstate <= dci_pkg::DCI_SELF_REF; // RULE_03
						else
							pstate <= dci_pkg::DCI_PD_PRE; // RULE_03
					end else if (|open_rows) begin
						pstate <= dci_pkg::DCI_ACTIVE;
					end else begin
						pstate <= dci_pkg::DCI_IDLE;
					end
				end
				dci_pkg::DCI_PD_PRE, dci_pkg::DCI_PD_ACT: begin
					if (edge_ck && cke_s2)
						pstate <= (|open_rows) ? dci_pkg::DCI_ACTIVE : dci_pkg::DCI_IDLE;
				end
				dci_pkg::DCI_SELF_REF: begin
					if (cke_s2)
						pstate <= dci_pkg::DCI_IDLE; // RULE_04
				end
				default: pstate <= dci_pkg::DCI_IDLE;
			endcase
		end
	end

	// Clocks and input buffer enables
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clocks_run <= 1'b0;
			buf_ca_en <= 1'b0;
			buf_ck_odt_en <= 1'b0;
		end else begin
			clocks_run <= !pd_state && cke_s2; // RULE_02
			buf_ca_en <= !pd_state; // RULE_06
			buf_ck_odt_en <= (pstate != dci_pkg::DCI_SELF_REF); // RULE_06
		end
	end

	// One open-row flag per bank; an all-bank precharge clears every flag
	for (genvar b = 0; b < dci_pkg::BANKS; b++) begin : g_bank
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				open_rows[b] <= 1'b0;
			end else if (cmd_take && buf_ca_en) begin
				if (!act_s2 && int'(bank_s2) == b)
					open_rows[b] <= 1'b1;
				else if (act_s2 && cmd_s2 == dci_pkg::CMD_PRE
					&& (addr_s2[dci_pkg::AP_POS] || int'(bank_s2) == b))
					open_rows[b] <= 1'b0;
			end
		end
	end

	// Command decode
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			op_valid <= 1'b0;
			op <= dci_pkg::DCI_OP_NONE;
			op_bank <= '0;
			op_row <= '0;
			op_col <= 14'h0000;
			cmd_parity <= 1'b0;
		end else begin
			op_valid <= 1'b0;
			if (cmd_take && buf_ca_en) begin
				op_bank <= bank_s2;
				op_col <= addr_s2;
				cmd_parity <= ^{act_s2, cmd_s2, addr_s2, bank_s2}; // RULE_14
				if (!act_s2) begin
					op_valid <= 1'b1;
					op <= dci_pkg::DCI_OP_ACT; // RULE_12
					op_row <= {1'b0, ~cmd_s2, addr_s2}; // RULE_13
				end else begin
					op_valid <= (cmd_s2 != dci_pkg::CMD_NOP);
					unique case (cmd_s2) // RULE_13
						dci_pkg::CMD_READ:  op <= dci_pkg::DCI_OP_READ;
						dci_pkg::CMD_WRITE: op <= dci_pkg::DCI_OP_WRITE;
						dci_pkg::CMD_PRE:   op <= dci_pkg::DCI_OP_PRE;
						dci_pkg::CMD_REF:   op <= dci_pkg::DCI_OP_REF;
						default:            op <= dci_pkg::DCI_OP_NONE;
					endcase
				end
			end
		end
	end

	// Termination
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			term_dq_en <= 1'b0;
			term_ca_en <= 1'b0;
		end else begin
			term_ca_en <= 1'b0; // RULE_10
			if (edge_ck && buf_ck_odt_en)
				term_dq_en <= rtt_nom_en && odt_s2; // RULE_09 RULE_11
			else if (!rtt_nom_en)
				term_dq_en <= 1'b0; // RULE_11
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dci_pkg.sv
// Shared constants and types for the control-input link
package dci_pkg;
	localparam int ROW_W   = 18;
	localparam int BANKS   = 16;
	localparam int BANK_W  = 4;
	localparam int BURST_CYCLES = 4;
	localparam logic [2:0] CMD_NOP   = 3'h7;
	localparam logic [2:0] CMD_READ  = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_PRE   = 3'h2;
	localparam logic [2:0] CMD_REF   = 3'h1;
	localparam int ROWHI_POS = 14;
	localparam int AP_POS    = 10;
	typedef enum logic [2:0] {
		DCI_IDLE, DCI_ACTIVE, DCI_PD_PRE, DCI_PD_ACT, DCI_SELF_REF
	} dci_pstate_t;
	typedef enum logic [2:0] {
		DCI_OP_NONE, DCI_OP_ACT, DCI_OP_READ, DCI_OP_WRITE, DCI_OP_PRE, DCI_OP_REF
	} dci_op_t;
endpackage

// >>> testbench/dci_properties.sv
// Link-level properties of the control-input interface
`timescale 1ns/1ps
`default_nettype none
module dci_properties (
	// Clock and reset
	input wire logic                       clock,
	input wire logic                       reset_n,
	// Link signals
	input wire logic                       ck_t,
	input wire logic                       ck_c,
	input wire logic                       cke,
	input wire logic                       cs_n,
	input wire logic                       act_n,
	input wire logic [2:0]                 cmd,
	input wire logic [13:0]                addr,
	input wire logic [dci_pkg::BANK_W-1:0] bank,
	input wire logic                       odt
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_clock_pair_diff: assert property (ck_c == !ck_t)
		else $error("clock pair not complementary");
	a_stable_at_rise: assert property ($rose(ck_t) |-> $stable({cs_n, act_n, cmd, addr, bank, odt}))
		else $error("link inputs moved at the sampling crossing");
	a_link_period: assert property ($rose(ck_t) |-> ##2 $fell(ck_t) ##2 $rose(ck_t))
		else $error("link clock period wrong");
	a_select_period: assert property ($fell(cs_n) |-> !cs_n [*4])
		else $error("select shorter than one link period");
	a_select_then_rise: assert property ($fell(cs_n) |=> $rose(ck_t))
		else $error("select not aligned to link clock rise");
	a_burst_cke_hold: assert property ($rose(ck_t) && !cs_n && act_n
		&& (cmd == dci_pkg::CMD_READ || cmd == dci_pkg::CMD_WRITE) |-> cke [*8])
		else $error("clock enable dropped during burst");
	a_act_with_select: assert property (!act_n |-> !cs_n)
		else $error("activate without select");
	a_odt_before_rise: assert property ($changed(odt) |-> ##1 $rose(ck_t))
		else $error("termination control not set up before rise");
endmodule
`default_nettype wire

// >>> testbench/ddr4_control_input_interface_tb.sv
// Self-checking bench joining controller and memory ends
`timescale 1ns/1ps
`default_nettype none
module ddr4_control_input_interface_tb;
	logic                 clock = 1'b0, reset_n = 1'b0, req_valid = 1'b0;
	dci_pkg::dci_op_t     req_op = dci_pkg::DCI_OP_NONE;
	logic [3:0]           req_bank = 4'h0;
	logic [17:0]          req_addr = 18'h00000;
	logic                 req_cke = 1'b0, req_odt = 1'b0, rtt_nom_en = 1'b1;
	logic                 req_ready, op_valid, cmd_parity, clocks_run, buf_ca_en;
	logic                 buf_ck_odt_en, term_dq_en, term_ca_en;
	dci_pkg::dci_op_t     op;
	dci_pkg::dci_pstate_t pstate;
	logic [3:0]           op_bank;
	logic [17:0]          op_row;
	logic [13:0]          op_col;
	logic [25:0]          note;
	logic [25:0]          notes [$];
	int                   bad_count = 0, checks_done = 0, cycles = 0, i;
	dci_if link_if ();
	dci_ctrl dci_ctrl_i (.clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req_op(req_op),
		.req_bank(req_bank), .req_addr(req_addr), .req_cke(req_cke), .req_odt(req_odt),
		.req_ready(req_ready), .link(link_if));
	dci_mem dci_mem_i (.clock(clock), .reset_n(reset_n), .link(link_if), .rtt_nom_en(rtt_nom_en),
		.op_valid(op_valid), .op(op), .op_bank(op_bank), .op_row(op_row), .op_col(op_col),
		.cmd_parity(cmd_parity), .pstate(pstate), .clocks_run(clocks_run), .buf_ca_en(buf_ca_en),
		.buf_ck_odt_en(buf_ck_odt_en), .term_dq_en(term_dq_en), .term_ca_en(term_ca_en));
	dci_properties dci_properties_i (.clock(clock), .reset_n(reset_n), .ck_t(link_if.ck_t),
		.ck_c(link_if.ck_c), .cke(link_if.cke), .cs_n(link_if.cs_n), .act_n(link_if.act_n),
		.cmd(link_if.cmd), .addr(link_if.addr), .bank(link_if.bank), .odt(link_if.odt));
	always #25 clock = ~clock;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Parity over all command and address lines except select, enable, termination
	function automatic logic exp_parity(input dci_pkg::dci_op_t o, input logic [3:0] b,
		input logic [17:0] a);
		logic [2:0] c;
		c = (o == dci_pkg::DCI_OP_READ) ? dci_pkg::CMD_READ
			: (o == dci_pkg::DCI_OP_WRITE) ? dci_pkg::CMD_WRITE
			: (o == dci_pkg::DCI_OP_PRE) ? dci_pkg::CMD_PRE : dci_pkg::CMD_REF;
		if (o == dci_pkg::DCI_OP_ACT)
			c = ~a[16:14];
		return ^{o != dci_pkg::DCI_OP_ACT, c, a[13:0], b};
	endfunction
	// Holds the request until the edge where ready is sampled high
	task automatic send(input dci_pkg::dci_op_t o, input logic c, input logic d);
		int n = 0;
		req_valid = 1'b1;
		req_op = o;
		req_bank = 4'($urandom);
		req_addr = 18'($urandom) & 18'h1FFFF;
		req_cke = c;
		req_odt = d;
		do begin
			@(posedge clock);
			n++;
		end while (req_ready !== 1'b1 && n < 20);
		check("ready", req_ready, 1'b1);
		if (o != dci_pkg::DCI_OP_NONE && c)
			notes.push_back({o, req_bank, req_addr, exp_parity(o, req_bank, req_addr)});
		#2;
	endtask
	task automatic idle(input int k);
		req_valid = 1'b0;
		repeat (k) @(posedge clock);
		#2;
	endtask
	always @(posedge clock) begin
		if (op_valid === 1'b1) begin
			if (notes.size() == 0) begin
				check("unexpected op", 1'b1, 1'b0);
			end else begin
				note = notes.pop_front();
				check("op", op, note[25:23]);
				check("bank", op_bank, note[22:19]);
				check("parity", cmd_parity, note[0]);
				if (note[25:23] == dci_pkg::DCI_OP_ACT)
					check("row", op_row, note[18:1]);
				else
					check("col", op_col, note[14:1]);
			end
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'hf5a9b78a));
		repeat (4) @(posedge clock);
		#2;
		reset_n = 1'b1;
		send(dci_pkg::DCI_OP_NONE, 1'b1, 1'b0);
		idle(20);
		check("clocks run", clocks_run, 1'b1);
		for (i = 1; i < 6; i++) send(dci_pkg::dci_op_t'(i), 1'b1, 1'($urandom));
		send(dci_pkg::DCI_OP_ACT, 1'b1, 1'b0);
		send(dci_pkg::DCI_OP_READ, 1'b1, 1'b0);
		send(dci_pkg::DCI_OP_NONE, 1'b0, 1'b0);
		idle(40);
		check("notes left", notes.size(), 32'h0);
		check("active powerdown", pstate, dci_pkg::DCI_PD_ACT);
		check("ca buffers", buf_ca_en, 1'b0);
		check("ck odt buffers", buf_ck_odt_en, 1'b1);
		check("clocks stop", clocks_run, 1'b0);
		send(dci_pkg::DCI_OP_NONE, 1'b1, 1'b1);
		idle(20);
		check("dq term on", term_dq_en, 1'b1);
		check("ca term", term_ca_en, 1'b0);
		rtt_nom_en = 1'b0;
		idle(10);
		check("dq term ignored", term_dq_en, 1'b0);
		reset_n = 1'b0;
		idle(3);
		reset_n = 1'b1;
		send(dci_pkg::DCI_OP_NONE, 1'b1, 1'b0);
		send(dci_pkg::DCI_OP_REF, 1'b0, 1'b0);
		idle(30);
		check("self refresh", pstate, dci_pkg::DCI_SELF_REF);
		check("sr buffers", buf_ck_odt_en, 1'b0);
		send(dci_pkg::DCI_OP_NONE, 1'b1, 1'b0);
		idle(30);
		check("sr exit", pstate == dci_pkg::DCI_SELF_REF, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
